// [design/host_port_dev.sv]
// Purpose: Device end of the host bus port, both strobe flavours
// Assumes: Bus clock is far slower than i_ref_clk (see BUS_DIV)
// Notes: Every access stalls on wait until the user side acknowledges
//
// What this block does
// [RULE1] Host holds device reset one input clock
// [RULE2] Split access starts at clocked strobe and select
// [RULE3] Split write data due by fourth edge
// [RULE4] Device pulls wait; host holds strobes till rise
// [RULE5] Split: wait floats soon after strobe rises
// [RULE6] Host holds address and select through strobes
// [RULE7] Split strobes idle one bus clock between
// [RULE8] Split little-endian lane to address mapping
// [RULE9] Split big-endian lane to address mapping
// [RULE10] Address bit zero ignored; word aligned
// [RULE11] Single access starts at clocked strobe and select
// [RULE12] Single write data due by fourth edge
// [RULE13] Single: wait holds host; no early rise
// [RULE14] Single: wait floats soon after strobe rises
// [RULE15] Single strobes idle one bus clock between
// [RULE16] Single lanes from high enable and A0
// [RULE17] Single strobe flavour is little-endian only
// [RULE18] Flavour and byte order strapped at reset
// [RULE19] Wait driven only during a selected access
`timescale 1ns/1ps
module host_port_dev
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Straps
  input wire logic i_split_mode,
  input wire logic i_big_endian,
  // Pins
  host_port_if.dev bus,
  // User request
  output logic o_req,
  output logic o_req_write,
  output logic o_req_mem,
  output logic [WORD_W-1:0] o_req_word_addr,
  output logic o_req_odd,
  output logic [1:0] o_req_lanes,
  output logic [DATA_W-1:0] o_req_wdata,
  // User answer
  input wire logic i_ack,
  input wire logic [DATA_W-1:0] i_rdata,
  // Strapped mode
  output logic o_split_mode,
  output logic o_big_endian
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WDATA = 2'b01,
    ST_REQ = 2'b10,
    ST_RELEASE = 2'b11
  } dev_state_e;

  typedef struct packed {
    dev_state_e st;
    logic strapped;
    logic split;
    logic big;
    logic bclk_q;
    logic [2:0] edges;
    logic is_wr;
    logic mem;
    logic [1:0] lanes;
    logic odd;
    logic [WORD_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic drv;
    logic wait_oe;
    logic wait_out_n;
    logic req;
  } dev_s;

  localparam int unsigned PIN_W = 12 + ADDR_W + DATA_W;
  localparam logic [2:0] WDATA_EDGE_C = 3'(WDATA_EDGE);

  dev_s state_reg;
  dev_s state_next;
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pins_s;
  logic s_bclk;
  logic s_rst_n;
  logic s_cs_n;
  logic s_mem;
  logic [ADDR_W-1:0] s_addr;
  logic s_l0w;
  logic s_l1w;
  logic s_l0r;
  logic s_l1r;
  logic s_wr;
  logic s_rd;
  logic s_bhe;
  logic [DATA_W-1:0] s_data;
  logic rise;
  logic any_wr;
  logic any_rd;
  logic [1:0] lanes;

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture: every host pin passes two flops
  assign pins = {bus.host_bus_clock, bus.dev_reset_n, bus.cs_n, bus.mem_sel,
                 bus.lane0_write_strobe_n, bus.lane1_write_strobe_n,
                 bus.lane0_read_strobe_n, bus.lane1_read_strobe_n,
                 bus.write_strobe_n, bus.read_strobe_n,
                 bus.high_lane_enable_n, 1'b0, bus.addr, bus.data};

  pin_sync #(
    .W(PIN_W),
    .INIT({12'h7fe, {ADDR_W{1'b0}}, {DATA_W{1'b0}}})
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pins(pins),
    .o_sync(pins_s)
  );

  assign {s_bclk, s_rst_n, s_cs_n, s_mem, s_l0w, s_l1w, s_l0r, s_l1r,
          s_wr, s_rd, s_bhe} = pins_s[PIN_W-1:PIN_W-11];
  assign s_addr = pins_s[ADDR_W+DATA_W-1:DATA_W];
  assign s_data = pins_s[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode per flavour
  always_comb begin
    rise = s_bclk & ~state_reg.bclk_q;
    if (state_reg.split) begin
      any_wr = ~(s_l0w & s_l1w);
      any_rd = ~(s_l0r & s_l1r);
      lanes = any_wr ? {~s_l1w, ~s_l0w} : {~s_l1r, ~s_l0r}; // RULE8 RULE9
    end else begin
      any_wr = ~s_wr;
      any_rd = ~s_rd;
      lanes = {~s_bhe, ~s_addr[0]}; // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.bclk_q = s_bclk;
    state_next.req = 1'b0;
    if (!state_reg.strapped) begin
      // Straps settle once after reset release
      state_next.strapped = 1'b1; // RULE18
      state_next.split = i_split_mode; // RULE18
      state_next.big = i_split_mode & i_big_endian; // RULE17
    end
    case (state_reg.st)
      ST_IDLE: begin
        state_next.wait_oe = 1'b0;
        state_next.drv = 1'b0;
        // Start only on a bus clock edge with select and a strobe
        if (state_reg.strapped && rise && !s_cs_n && (any_wr || any_rd)) begin // RULE2 RULE11
          state_next.is_wr = any_wr;
          state_next.mem = s_mem;
          state_next.lanes = lanes;
          state_next.odd = odd_of(state_reg.big, lanes); // RULE8 RULE9 RULE17
          state_next.waddr = s_addr[ADDR_W-1:1]; // RULE10
          state_next.edges = 3'h0;
          state_next.wait_oe = 1'b1; // RULE4 RULE13 RULE19
          state_next.wait_out_n = 1'b0; // RULE4 RULE13
          if (any_wr) begin
            state_next.st = ST_WDATA;
          end else begin
            state_next.req = 1'b1;
            state_next.st = ST_REQ;
          end
        end
      end
      ST_WDATA: begin
        // Data is only trusted at the fourth edge
        if (rise) begin
          state_next.edges = state_reg.edges + 3'h1;
          if (state_reg.edges + 3'h1 == WDATA_EDGE_C) begin // RULE3 RULE12
            state_next.wdata = s_data;
            state_next.req = 1'b1;
            state_next.st = ST_REQ;
          end
        end
      end
      ST_REQ: begin
        if (i_ack) begin
          state_next.rdata = i_rdata;
          state_next.drv = ~state_reg.is_wr;
          state_next.wait_out_n = 1'b1; // RULE4 RULE13
          state_next.st = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // Host keeps strobes low until it sees wait high
        if ((!any_wr && !any_rd) || s_cs_n) begin // RULE6
          state_next.wait_oe = 1'b0; // RULE5 RULE14 RULE19
          state_next.drv = 1'b0;
          state_next.st = ST_IDLE; // RULE7 RULE15
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
    // Pin reset from the host restarts the port and re-reads straps
    if (!s_rst_n) begin // RULE1
      state_next = '0;
      state_next.wait_out_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
      state_reg.wait_out_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  assign bus.dev_data_out = state_reg.rdata;
  assign bus.dev_data_oe = state_reg.drv;
  assign bus.wait_out_n = state_reg.wait_out_n;
  assign bus.wait_oe = state_reg.wait_oe;
  assign o_req = state_reg.req;
  assign o_req_write = state_reg.is_wr;
  assign o_req_mem = state_reg.mem;
  assign o_req_word_addr = state_reg.waddr;
  assign o_req_odd = state_reg.odd;
  assign o_req_lanes = state_reg.lanes;
  assign o_req_wdata = state_reg.wdata;
  assign o_split_mode = state_reg.split;
  assign o_big_endian = state_reg.big;

endmodule : host_port_dev

// [design/host_port_host.sv]
// Purpose: Host end of the host bus port, a simple bus controller
// Assumes: Bus clock made here by dividing i_ref_clk by BUS_DIV
// Notes: Pins other than dev_reset_n change on the bus clock falling edge for setup margin
`timescale 1ns/1ps
module host_port_host
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Mode, must match the device straps
  input wire logic i_split_mode,
  input wire logic i_big_endian,
  // Pins
  host_port_if.host bus,
  // Command
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic i_cmd_mem,
  input wire logic i_cmd_size16,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [DATA_W-1:0] i_cmd_wdata,
  output logic o_cmd_ready,
  // Answer
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata
);

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_STROBE = 2'b10,
    HS_GAP = 2'b11
  } host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [DIV_W-1:0] div;
    logic bclk;
    logic [1:0] rst_cnt;
    logic rst_n;
    logic ready;
    logic is_wr;
    logic [1:0] lanes;
    logic cs_n;
    logic mem;
    logic [ADDR_W-1:0] addr;
    logic [3:0] strobes_n;
    logic wr_n;
    logic rd_n;
    logic bhe_n;
    logic [DATA_W-1:0] wdata;
    logic data_oe;
    logic seen_low;
    logic done;
    logic [DATA_W-1:0] rdata;
  } host_s;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BUS_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(BUS_HALF);
  localparam logic [1:0] RST_LAST = 2'(RESET_HOLD_CYCLES - 1);

  host_s state_reg;
  host_s state_next;
  logic [DATA_W:0] in_s;
  logic s_wait_n;
  logic fall;

  // Wait and read data come from the device pins
  pin_sync #(
    .W(DATA_W + 1),
    .INIT({1'b1, {DATA_W{1'b0}}})
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pins({bus.wait_n, bus.data}),
    .o_sync(in_s)
  );
  assign s_wait_n = in_s[DATA_W];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.div = (state_reg.div == DIV_LAST) ? '0 : state_reg.div + 1'b1;
    state_next.bclk = (state_next.div >= DIV_HALF);
    fall = (state_reg.div == DIV_LAST);
    // Device reset held at least one input clock period
    if (!state_reg.rst_n) begin
      state_next.rst_cnt = state_reg.rst_cnt + 2'h1;
      state_next.rst_n = (state_reg.rst_cnt == RST_LAST); // RULE1
    end
    case (state_reg.st)
      HS_IDLE: begin
        state_next.ready = state_reg.rst_n;
        if (fall && state_reg.ready && i_cmd_valid) begin
          state_next.ready = 1'b0;
          state_next.is_wr = i_cmd_write;
          state_next.lanes = lanes_of(i_big_endian & i_split_mode, i_cmd_size16,
                                      i_cmd_addr[0]);
          state_next.cs_n = 1'b0;
          state_next.mem = i_cmd_mem;
          state_next.addr = i_cmd_addr;
          state_next.bhe_n = ~state_next.lanes[1]; // RULE16 RULE17
          state_next.wdata = i_cmd_wdata;
          state_next.st = HS_SETUP;
        end
      end
      HS_SETUP: begin
        // Address and select settled a full bus clock before strobes
        if (fall) begin
          if (i_split_mode) begin
            state_next.strobes_n = state_reg.is_wr ? {~state_reg.lanes, 2'h3}
                                                   : {2'h3, ~state_reg.lanes};
          end else begin
            state_next.wr_n = ~state_reg.is_wr;
            state_next.rd_n = state_reg.is_wr;
          end
          state_next.data_oe = state_reg.is_wr; // RULE3 RULE12
          state_next.seen_low = 1'b0;
          state_next.st = HS_STROBE;
        end
      end
      HS_STROBE: begin
        if (!s_wait_n) begin
          state_next.seen_low = 1'b1;
        end
        // Strobes stay low until wait has gone low and back high
        if (fall && state_reg.seen_low && s_wait_n) begin // RULE4 RULE13
          state_next.strobes_n = 4'hf;
          state_next.wr_n = 1'b1;
          state_next.rd_n = 1'b1;
          state_next.rdata = in_s[DATA_W-1:0];
          state_next.done = 1'b1;
          state_next.st = HS_GAP;
        end
      end
      HS_GAP: begin
        // Select and address held past the strobe rise
        if (fall) begin // RULE6
          state_next.data_oe = 1'b0;
          state_next.cs_n = 1'b1;
          state_next.st = HS_IDLE; // RULE7 RULE15
        end
      end
      default: begin
        state_next.st = HS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset pin asserted from reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
      state_reg.cs_n <= 1'b1;
      state_reg.strobes_n <= 4'hf;
      state_reg.wr_n <= 1'b1;
      state_reg.rd_n <= 1'b1;
      state_reg.bhe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and user outputs from flops
  assign bus.host_bus_clock = state_reg.bclk;
  assign bus.dev_reset_n = state_reg.rst_n;
  assign bus.cs_n = state_reg.cs_n;
  assign bus.mem_sel = state_reg.mem;
  assign bus.addr = state_reg.addr;
  assign {bus.lane1_write_strobe_n, bus.lane0_write_strobe_n,
          bus.lane1_read_strobe_n, bus.lane0_read_strobe_n} = state_reg.strobes_n;
  assign bus.write_strobe_n = state_reg.wr_n;
  assign bus.read_strobe_n = state_reg.rd_n;
  assign bus.high_lane_enable_n = state_reg.bhe_n;
  assign bus.host_data_out = state_reg.wdata;
  assign bus.host_data_oe = state_reg.data_oe;
  assign o_cmd_ready = state_reg.ready;
  assign o_done = state_reg.done;
  assign o_rdata = state_reg.rdata;

endmodule : host_port_host

// [design/host_port_if.sv]
// Purpose: Pin bundle between the host bus controller and the device port
// Assumes: Open wait line is pulled high when nobody drives it
// Notes: Data bus level is resolved here from the two enables
`timescale 1ns/1ps
interface host_port_if;
  import host_port_pkg::*;

  logic host_bus_clock;
  logic dev_reset_n;
  logic cs_n;
  logic mem_sel;
  logic [ADDR_W-1:0] addr;
  logic lane0_write_strobe_n;
  logic lane1_write_strobe_n;
  logic lane0_read_strobe_n;
  logic lane1_read_strobe_n;
  logic write_strobe_n;
  logic read_strobe_n;
  logic high_lane_enable_n;
  logic [DATA_W-1:0] host_data_out;
  logic host_data_oe;
  logic [DATA_W-1:0] dev_data_out;
  logic dev_data_oe;
  logic wait_out_n;
  logic wait_oe;
  logic wait_n;
  logic [DATA_W-1:0] data;

  // Pull-up on wait, keeper-free data bus
  assign wait_n = wait_oe ? wait_out_n : 1'b1;
  assign data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '0);

  modport host (
    output host_bus_clock, dev_reset_n, cs_n, mem_sel, addr,
    output lane0_write_strobe_n, lane1_write_strobe_n,
    output lane0_read_strobe_n, lane1_read_strobe_n,
    output write_strobe_n, read_strobe_n, high_lane_enable_n,
    output host_data_out, host_data_oe,
    input wait_n, data
  );

  modport dev (
    input host_bus_clock, dev_reset_n, cs_n, mem_sel, addr,
    input lane0_write_strobe_n, lane1_write_strobe_n,
    input lane0_read_strobe_n, lane1_read_strobe_n,
    input write_strobe_n, read_strobe_n, high_lane_enable_n,
    input data,
    output dev_data_out, dev_data_oe, wait_out_n, wait_oe
  );
endinterface : host_port_if

// [design/host_port_pkg.sv]
// Purpose: Shared constants, types and lane helpers of the host bus port
// Assumes: Both ends run on one 250 MHz reference clock
// Notes: The host bus clock is a divided enable, also driven out as a pin
package host_port_pkg;

  // Reference clock and bus clock divider
  localparam int unsigned REF_CLK_MHZ = 250;
  localparam int unsigned BUS_DIV = 8;
  localparam int unsigned BUS_HALF = BUS_DIV / 2;
  localparam int unsigned DIV_W = $clog2(BUS_DIV);

  // Reset low time in input clock periods; one spare covers sync skew
  localparam int unsigned RESET_MIN_CLKS = 1;
  localparam int unsigned RESET_HOLD_CYCLES = RESET_MIN_CLKS + 1;

  // Write data is due by this bus clock rising edge after start
  localparam int unsigned WDATA_EDGE = 4;
  // Idle bus clocks between strobes
  localparam int unsigned GAP_BUS_CLKS = 1;

  // Widths
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORD_W = ADDR_W - 1;

  // Lane enables: bit 0 is D[7:0], bit 1 is D[15:8]
  localparam logic [1:0] LANES_BOTH = 2'h3;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;

  // Lanes used by a transfer of given size and byte offset
  function automatic logic [1:0] lanes_of(input logic big, input logic size16,
                                          input logic odd);
    if (size16) begin
      lanes_of = LANES_BOTH;
    end else if (big) begin
      lanes_of = odd ? LANE_LOW : LANE_HIGH;
    end else begin
      lanes_of = odd ? LANE_HIGH : LANE_LOW;
    end
  endfunction : lanes_of

  // Byte offset named by a single lane; a word reports even
  function automatic logic odd_of(input logic big, input logic [1:0] lanes);
    if (lanes == LANES_BOTH) begin
      odd_of = 1'b0;
    end else begin
      odd_of = big ? (lanes == LANE_LOW) : (lanes == LANE_HIGH);
    end
  endfunction : odd_of

endpackage : host_port_pkg

// [design/pin_sync.sv]
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Multi-bit groups are quasi-static when sampled
// Notes: Stage one feeds stage two only
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Levels
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  // Metastability filter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= INIT;
      o_sync <= INIT;
    end else begin
      meta_reg <= i_pins;
      o_sync <= meta_reg;
    end
  end
endmodule : pin_sync

// [dv/generic_host_bus_port_bench.sv]
// Purpose: Host end against device end, user sides driven here
// Assumes: Straps match on both ends; reset re-samples them
// Notes: Byte reads compare only the lanes in use
`timescale 1ns/1ps
module generic_host_bus_port_bench;
  import host_port_pkg::*;
  localparam int CYCLE_LIMIT = 20000;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic split_mode = 1'b1;
  logic big_endian = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_mem = 1'b0;
  logic cmd_size16 = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0;
  logic ack = 1'b0;
  logic [DATA_W-1:0] ack_rdata = '0;
  logic cmd_ready, done, req, req_write, req_mem, req_odd, dev_split, dev_big;
  logic [DATA_W-1:0] host_rdata;
  logic [DATA_W-1:0] req_wdata;
  logic [WORD_W-1:0] req_word;
  logic [1:0] req_lanes;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  host_port_if bus_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Both ends face each other; checker sits on the shared pins
  host_port_host host_port_host_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_split_mode(split_mode), .i_big_endian(big_endian), .bus(bus_if),
    .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_mem(cmd_mem),
    .i_cmd_size16(cmd_size16), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
    .o_cmd_ready(cmd_ready), .o_done(done), .o_rdata(host_rdata));
  host_port_dev host_port_dev_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_split_mode(split_mode), .i_big_endian(big_endian), .bus(bus_if),
    .o_req(req), .o_req_write(req_write), .o_req_mem(req_mem),
    .o_req_word_addr(req_word), .o_req_odd(req_odd), .o_req_lanes(req_lanes),
    .o_req_wdata(req_wdata), .i_ack(ack), .i_rdata(ack_rdata),
    .o_split_mode(dev_split), .o_big_endian(dev_big));
  host_port_props host_port_props_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .cs_n(bus_if.cs_n), .mem_sel(bus_if.mem_sel), .addr(bus_if.addr),
    .lane0_write_strobe_n(bus_if.lane0_write_strobe_n),
    .lane1_write_strobe_n(bus_if.lane1_write_strobe_n),
    .lane0_read_strobe_n(bus_if.lane0_read_strobe_n),
    .lane1_read_strobe_n(bus_if.lane1_read_strobe_n),
    .write_strobe_n(bus_if.write_strobe_n), .read_strobe_n(bus_if.read_strobe_n),
    .high_lane_enable_n(bus_if.high_lane_enable_n),
    .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe),
    .wait_oe(bus_if.wait_oe), .wait_n(bus_if.wait_n));

  // Clock and hang guard
  always #2 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Reset with new straps; the device must take them afresh
  task automatic restart(input logic split, input logic big);
    int n;
    @(negedge i_ref_clk);
    i_rst = 1'b1;
    split_mode = split;
    big_endian = big;
    repeat (6) @(negedge i_ref_clk);
    i_rst = 1'b0;
    // Pin reset must still be low one cycle after release
    @(negedge i_ref_clk);
    check("pin reset", 16'h0, {15'h0, bus_if.dev_reset_n});
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(negedge i_ref_clk);
    check("cmd ready", 16'h1, {15'h0, cmd_ready});
    repeat (8) @(negedge i_ref_clk);
    check("split strap", {15'h0, split}, {15'h0, dev_split});
    check("order strap", {15'h0, big & split}, {15'h0, dev_big});
  endtask : restart

  // One access: kind 0 word, 1 even byte, 2 odd byte; stall delays the ack
  task automatic xfer(input logic wr, input logic [1:0] kind, input int stall);
    logic [ADDR_W-1:0] a;
    logic [1:0] lanes;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] wd;
    int n;
    a = {8'h5a, wr, 7'h31, kind == 2'h2};
    if (kind == 2'h0) lanes = 2'h3;
    else if (big_endian && split_mode) lanes = (kind == 2'h2) ? 2'h1 : 2'h2;
    else lanes = (kind == 2'h2) ? 2'h2 : 2'h1;
    mask = {{8{lanes[1]}}, {8{lanes[0]}}};
    wd = 16'hc3a5 ^ {12'h0, kind, wr, 1'b1};
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_mem = kind[0];
    cmd_size16 = (kind == 2'h0);
    cmd_addr = a;
    cmd_wdata = wd;
    for (n = 0; n < 100 && cmd_ready === 1'b1; n++) @(negedge i_ref_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 300 && req !== 1'b1; n++) @(negedge i_ref_clk);
    check("req", 16'h1, {15'h0, req});
    check("req write", {15'h0, wr}, {15'h0, req_write});
    check("req mem", {15'h0, kind[0]}, {15'h0, req_mem});
    check("word addr", a[ADDR_W-1:1], req_word);
    check("lanes", {14'h0, lanes}, {14'h0, req_lanes});
    check("odd", {15'h0, kind == 2'h2}, {15'h0, req_odd});
    if (wr) check("wdata", wd & mask, req_wdata & mask);
    repeat (stall) @(negedge i_ref_clk);
    ack = 1'b1;
    ack_rdata = ~wd;
    @(negedge i_ref_clk);
    ack = 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge i_ref_clk);
    check("done", 16'h1, {15'h0, done});
    if (!wr) check("rdata", ~wd & mask, host_rdata & mask);
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(negedge i_ref_clk);
  endtask : xfer

  // Reads and writes of every size, back to back, with rising stalls
  task automatic sweep();
    for (int w = 0; w < 2; w++) begin
      for (int k = 0; k < 3; k++) begin
        xfer(w[0], k[1:0], k * 4);
      end
    end
  endtask : sweep

  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Split little, split big, then single with the order strap set
  initial begin
    restart(1'b1, 1'b0);
    sweep();
    restart(1'b1, 1'b1);
    sweep();
    restart(1'b0, 1'b1);
    sweep();
    complete_run();
  end
endmodule : generic_host_bus_port_bench

// [dv/host_port_props.sv]
// Purpose: Pin level checks between the host and device ends
// Assumes: One reference clock domain, reset active high
// Notes: Flavour is inferred from which strobe group moves
`timescale 1ns/1ps
module host_port_props
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Host driven pins
  input wire logic cs_n,
  input wire logic mem_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic lane0_write_strobe_n,
  input wire logic lane1_write_strobe_n,
  input wire logic lane0_read_strobe_n,
  input wire logic lane1_read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic high_lane_enable_n,
  input wire logic host_data_oe,
  // Device driven pins
  input wire logic dev_data_oe,
  input wire logic wait_oe,
  input wire logic wait_n
);
  logic split_idle;
  logic single_idle;
  logic read_idle;
  logic write_idle;
  logic strb_idle;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe groups at rest; a lane pair counts as one group
  assign split_idle = &{lane0_write_strobe_n, lane1_write_strobe_n,
                        lane0_read_strobe_n, lane1_read_strobe_n};
  assign single_idle = write_strobe_n & read_strobe_n;
  assign read_idle = lane0_read_strobe_n & lane1_read_strobe_n & read_strobe_n;
  assign write_idle = lane0_write_strobe_n & lane1_write_strobe_n & write_strobe_n;
  assign strb_idle = split_idle & single_idle;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Access start and release events
  sequence s_start; $fell(strb_idle); endsequence
  sequence s_end; $rose(strb_idle); endsequence
  sequence s_split_end; $rose(split_idle); endsequence
  sequence s_single_end; $rose(single_idle); endsequence
  sequence s_read_end; $rose(read_idle); endsequence

  // Half a bus period is four reference cycles
  property p_wait_sel; wait_oe |-> !cs_n; endproperty
  property p_wait_low; s_start |-> ##[1:12] !wait_n; endproperty
  property p_wait_first; s_end |-> $past(wait_n); endproperty
  property p_split_float; s_split_end |-> ##[1:4] !wait_oe; endproperty
  property p_single_float; s_single_end |-> ##[1:4] !wait_oe; endproperty
  property p_gap; s_end |-> strb_idle [*8]; endproperty
  property p_one_flavour; !(!split_idle && !single_idle); endproperty
  property p_hold;
    (!strb_idle && $past(!strb_idle)) |->
      !cs_n && $stable(addr) && $stable(mem_sel) && $stable(high_lane_enable_n);
  endproperty
  property p_read_data; s_read_end |-> $past(dev_data_oe); endproperty
  property p_write_data; !write_idle |-> host_data_oe && !dev_data_oe; endproperty

  a_wait_sel: assert property (p_wait_sel)
    else $error("wait driven while deselected");
  a_wait_low: assert property (p_wait_low)
    else $error("wait not pulled low after strobe");
  a_wait_first: assert property (p_wait_first)
    else $error("strobe released while wait low");
  a_split_float: assert property (p_split_float)
    else $error("wait not floated after lane strobe");
  a_single_float: assert property (p_single_float)
    else $error("wait not floated after strobe");
  a_gap: assert property (p_gap)
    else $error("strobe idle gap too short");
  a_one_flavour: assert property (p_one_flavour)
    else $error("both strobe flavours active");
  a_hold: assert property (p_hold)
    else $error("select or address moved in access");
  a_read_data: assert property (p_read_data)
    else $error("read released without device data");
  a_write_data: assert property (p_write_data)
    else $error("write strobe without host data");
endmodule : host_port_props
